//--- bench/interrupt_request_and_mask_bench.sv
// Self-checking testbench for the interrupt request and mask block
`timescale 1ns/1ps
module interrupt_request_and_mask_bench;
  import irm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_irq, irq, err;
  logic port3_pin1_input, port3_pin2_input, port3_pin3_input, grant_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] grant_source, c;
  logic [3:0] fire;
  logic [6:0] ev;
  logic [5:0] core_request;
  int err_total, cmp_count, cyc;
  logic [2:0] evbit [7] = '{3'h1, 3'h1, 3'h0, 3'h1, 3'h4, 3'h3, 3'h5};
  irm_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .port3_pin1_input, .port3_pin2_input,
    .port3_pin3_input, .stop_recovery_event(ev[0]), .uart_tx_event(ev[1]),
    .uart_rx_event(ev[2]), .baud_rate_generator(ev[3]), .eight_bit_timer(ev[4]),
    .sixteen_bit_timer(ev[5]), .low_voltage_flag(ev[6]), .grant_valid,
    .grant_source, .core_irq, .core_request, .irq);
  irm_src_model src_u (.pclk(pclk), .fire(fire), .ev(ev));
  always #20 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Hold the request until pready is seen high at a rising edge
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pins(input logic v);
    @(posedge pclk);
    port3_pin1_input <= v;
    port3_pin2_input <= v;
    port3_pin3_input <= v;
    repeat (4) @(posedge pclk);
  endtask
  // One-cycle service pulse from the core
  task automatic grant(input logic [2:0] s);
    @(posedge pclk);
    grant_valid  <= 1'b1;
    grant_source <= s;
    @(posedge pclk);
    grant_valid  <= 1'b0;
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      test_done;
    end
  end
  initial begin
    pclk             = 1'b0;
    presetn          = 1'b0;
    psel             = 1'b0;
    penable          = 1'b0;
    pwrite           = 1'b0;
    paddr            = 12'h000;
    pwdata           = 32'h0000_0000;
    port3_pin1_input = 1'b1;
    port3_pin2_input = 1'b1;
    port3_pin3_input = 1'b1;
    grant_valid      = 1'b0;
    grant_source     = 3'h0;
    fire             = 4'hF;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    xf(0, MASK_OFF, 0);
    chk(rd, 32'h0);
    chk(err, 1'b0);
    chk(core_irq, 1'b0);
    xf(1, REQ_OFF, 32'h3F);
    xf(0, REQ_OFF, 0);
    chk(rd, 32'h0);
    xf(0, INS_OFF, 0);
    chk(rd, 32'h0);
    xf(0, 12'h100, 0);
    chk(err, 1'b1);
    $display("reset and lock test done");
    xf(1, INS_OFF, INS_EI);
    xf(0, INS_OFF, 0);
    chk(rd, 32'h1);
    // Master off before the mask changes
    xf(1, INS_OFF, INS_DI);
    xf(1, REQ_OFF, 32'h3F);
    xf(1, MASK_OFF, 32'h3F);
    @(negedge pclk) chk(core_request, 6'h00);
    xf(1, INS_OFF, INS_EI);
    xf(0, REQ_OFF, 0);
    chk(rd, 32'h3F);
    xf(0, MASK_OFF, 0);
    chk(rd, 32'hBF);
    @(negedge pclk) chk(core_request, 6'h3F);
    chk(core_irq, 1'b1);
    // Grant of source 3 clears its flag and drops the master
    grant(3'h3);
    @(negedge pclk) chk(core_request, 6'h00);
    chk(core_irq, 1'b0);
    xf(0, REQ_OFF, 0);
    chk(rd, 32'h37);
    xf(0, MASK_OFF, 0);
    chk(rd, 32'h3F);
    xf(1, MASK_OFF, 32'h05);
    xf(1, INS_OFF, INS_EI);
    @(negedge pclk) chk(core_request, 6'h05);
    xf(1, REQ_OFF, 0);
    xf(0, REQ_OFF, 0);
    chk(rd, 32'h0);
    $display("flag and grant test done");
    for (int i = 0; i < 7; i++) begin
      xf(1, REQ_OFF, 0);
      @(posedge pclk) fire <= i[3:0];
      @(posedge pclk) fire <= 4'hF;
      xf(0, REQ_OFF, 0);
      chk(rd, 32'h1 << evbit[i]);
    end
    for (int i = 0; i < 4; i++) begin
      c = i[2:0];
      xf(1, REQ_OFF, {c[1:0], 6'h00});
      pins(0);
      xf(0, REQ_OFF, 0);
      chk(rd, {c[1:0], 3'h0, ~c[1] | c[0], 1'b1, ~c[0] | c[1]});
      xf(1, REQ_OFF, {c[1:0], 6'h00});
      pins(1);
      xf(0, REQ_OFF, 0);
      chk(rd, {c[1:0], 3'h0, c[1], 1'b0, c[0]});
    end
    $display("event and edge test done");
    xf(1, INS_OFF, INS_DI);
    xf(1, STAT_OFF, 32'h3);
    xf(1, REQ_OFF, 32'h01);
    @(negedge pclk) chk(core_request, 6'h00);
    chk(core_irq, 1'b0);
    xf(1, INS_OFF, INS_EI);
    @(negedge pclk) chk(irq, 1'b0);
    chk(core_irq, 1'b1);
    xf(1, IEN_OFF, 32'h1);
    @(negedge pclk) chk(irq, 1'b1);
    xf(1, STAT_OFF, 32'h1);
    @(negedge pclk) chk(irq, 1'b0);
    // A source code past the last flag only raises status
    grant(3'h6);
    xf(0, STAT_OFF, 0);
    chk(rd, 32'h2);
    xf(0, MASK_OFF, 0);
    chk(rd, 32'h85);
    $display("interrupt test done");
    test_done;
  end
endmodule // interrupt_request_and_mask_bench

//--- bench/irm_src_model.sv
// Model of the on-chip event sources feeding the request flags
`timescale 1ns/1ps
module irm_src_model (
  input  wire logic       pclk,
  input  wire logic [3:0] fire,
  output logic [6:0]      ev
);
  always_ff @(posedge pclk) begin
    ev <= (fire < 4'h7) ? (7'h01 << fire[2:0]) : 7'h00;
  end
endmodule // irm_src_model

//--- inc/irm_pkg.sv
// Constants and types for the interrupt request and mask block
package irm_pkg;
  localparam logic [11:0] REQ_OFF      = 12'h3E8;
  localparam logic [11:0] MASK_OFF     = 12'h3EC;
  localparam logic [11:0] INS_OFF      = 12'h000;
  localparam logic [11:0] STAT_OFF     = 12'h004;
  localparam logic [11:0] IEN_OFF      = 12'h008;
  localparam int          REQ_IDX      = 250;
  localparam int          MASK_IDX     = 251;
  localparam int          EDGE_HI      = 7;
  localparam int          EDGE_LO      = 6;
  localparam int          MASTER_BIT   = 7;
  localparam int          NSRC         = 6;
  localparam logic [7:0]  REQ_RST      = 8'h00;
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [1:0]  INS_EI       = 2'h1;
  localparam logic [1:0]  INS_DI       = 2'h2;
  localparam int          EV_W         = 2;
  typedef enum logic [1:0] {EDGE_FF, EDGE_FR, EDGE_RF, EDGE_BOTH} irm_edge_e;
endpackage

//--- rtl/irm_core.sv
// Interrupt request, edge select and source mask block with APB slave
`timescale 1ns/1ps
module irm_core
  import irm_pkg::*;
#(
  parameter int NUM_SRC = irm_pkg::NSRC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        port3_pin1_input,
  input  wire logic        port3_pin2_input,
  input  wire logic        port3_pin3_input,
  input  wire logic        stop_recovery_event,
  input  wire logic        uart_tx_event,
  input  wire logic        uart_rx_event,
  input  wire logic        baud_rate_generator,
  input  wire logic        eight_bit_timer,
  input  wire logic        sixteen_bit_timer,
  input  wire logic        low_voltage_flag,
  input  wire logic        grant_valid,
  input  wire logic [2:0]  grant_source,
  output logic             core_irq,
  output logic [5:0]       core_request,
  output logic             irq
);
  import irm_pkg::*;

  // Six flags fill bits 5:0 and the edge code owns 7:6, so no other count fits
  if (NUM_SRC != NSRC) begin : g_bad_src
    $error("irm_core serves exactly six sources");
  end

  logic [7:0] req_ff, nxt_req;
  logic [7:0] mask_ff, nxt_mask;
  logic       ei_seen_ff, nxt_ei_seen;
  logic [2:0] pin_ff, nxt_pin;
  logic [1:0] stat_ff, nxt_stat;
  logic [1:0] ien_ff, nxt_ien;
  logic [31:0] rd_ff, nxt_rd;
  logic       err_ff, nxt_err;
  logic       irq_prev_ff, nxt_irq_prev;
  logic       grant_ok;
  logic [5:0] hw_set;
  logic       p1_edge, p2_edge, p3_fall;
  logic       wr, rd;

  // Decoded address is used by both the read and the write path
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = hit(a, REQ_OFF) || hit(a, MASK_OFF) || hit(a, INS_OFF) ||
                hit(a, STAT_OFF) || hit(a, IEN_OFF);
  endfunction

  // Zero wait states: access phase completes at once
  assign pready  = 1'b1;
  assign prdata  = rd_ff;
  assign pslverr = err_ff;
  // Writes land at the access edge, the one at which the master sees pready high
  assign wr = psel && penable && pready && pwrite;
  // Source codes beyond the flag count are not services; they only raise status
  assign grant_ok = grant_valid && (grant_source < 3'(NUM_SRC));
  assign rd = psel && !penable && !pwrite;

  always_comb begin
    irm_edge_e sel;
    logic p1r, p1f, p2r, p2f;
    sel = irm_edge_e'(req_ff[EDGE_HI:EDGE_LO]);
    p1r = port3_pin1_input && !pin_ff[0];
    p1f = !port3_pin1_input && pin_ff[0];
    p2r = port3_pin2_input && !pin_ff[1];
    p2f = !port3_pin2_input && pin_ff[1];
    p3_fall = !port3_pin3_input && pin_ff[2];
    case (sel)
      EDGE_FF: begin
        p1_edge = p1f;
        p2_edge = p2f;
      end
      EDGE_FR: begin
        p1_edge = p1f;
        p2_edge = p2r;
      end
      EDGE_RF: begin
        p1_edge = p1r;
        p2_edge = p2f;
      end
      default: begin
        p1_edge = p1r | p1f;
        p2_edge = p2r | p2f;
      end
    endcase
  end

  always_comb begin
    hw_set = 6'h00;
    hw_set[2] = p1_edge;
    hw_set[1] = p3_fall | stop_recovery_event | uart_tx_event | baud_rate_generator;
    hw_set[0] = p2_edge | uart_rx_event;
    hw_set[5] = low_voltage_flag;
    hw_set[4] = eight_bit_timer;
    hw_set[3] = sixteen_bit_timer;
  end

  // Request flags and the unlock bit
  // Hardware sets are merged last, so an event never loses to a clear in the same cycle
  always_comb begin
    nxt_req     = req_ff;
    nxt_ei_seen = ei_seen_ff;
    if (wr && hit(paddr, REQ_OFF) && ei_seen_ff) begin
      nxt_req = pwdata[7:0];
    end
    if (wr && hit(paddr, INS_OFF) && (pwdata[1:0] == INS_EI)) begin
      nxt_ei_seen = 1'b1;
    end
    if (grant_ok) begin
      nxt_req[grant_source] = 1'b0;
    end
    nxt_req[5:0] = nxt_req[5:0] | hw_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff     <= REQ_RST;
      ei_seen_ff <= 1'b0;
    end else begin
      req_ff     <= nxt_req;
      ei_seen_ff <= nxt_ei_seen;
    end
  end

  // Source enables and master enable
  always_comb begin
    nxt_mask = mask_ff;
    if (wr && hit(paddr, MASK_OFF)) begin
      nxt_mask[5:0] = pwdata[5:0];
      nxt_mask[6]   = 1'b0;
    end
    // master enable is set only by instruction; a mask write leaves it alone
    if (wr && hit(paddr, INS_OFF)) begin
      if (pwdata[1:0] == INS_EI) begin
        nxt_mask[MASTER_BIT] = 1'b1;
      end else if (pwdata[1:0] == INS_DI) begin
        nxt_mask[MASTER_BIT] = 1'b0;
      end
    end
    // disable during vector cycle, wins over a same-cycle enable
    if (grant_ok) begin
      nxt_mask[MASTER_BIT] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= MASK_RST;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // Pin history resets high, so a pin held low at release gives one falling edge
  always_comb begin
    nxt_pin = {port3_pin3_input, port3_pin2_input, port3_pin1_input};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff <= 3'h7;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  // Status, its interrupt enable and the history for the rise detector
  always_comb begin
    nxt_stat     = stat_ff;
    nxt_ien      = ien_ff;
    nxt_irq_prev = core_irq;
    if (wr && hit(paddr, STAT_OFF)) begin
      nxt_stat = stat_ff & ~pwdata[1:0];
    end
    // Sets follow the clear so a new event is never lost
    nxt_stat[0] = nxt_stat[0] | (core_irq && !irq_prev_ff);
    nxt_stat[1] = nxt_stat[1] | (grant_valid && !grant_ok);
    if (wr && hit(paddr, IEN_OFF)) begin
      nxt_ien = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff     <= 2'h0;
      ien_ff      <= 2'h0;
      irq_prev_ff <= 1'b0;
    end else begin
      stat_ff     <= nxt_stat;
      ien_ff      <= nxt_ien;
      irq_prev_ff <= nxt_irq_prev;
    end
  end

  // Read data is loaded in the setup cycle and stands through the access phase
  always_comb begin
    nxt_rd  = rd_ff;
    nxt_err = 1'b0;
    if (psel && !penable && !is_mapped(paddr)) begin
      nxt_err = 1'b1;
    end
    if (rd) begin
      nxt_rd = 32'h0000_0000;
      if (hit(paddr, REQ_OFF)) nxt_rd[7:0] = req_ff;
      if (hit(paddr, MASK_OFF)) nxt_rd[7:0] = mask_ff;
      if (hit(paddr, STAT_OFF)) nxt_rd[1:0] = stat_ff;
      if (hit(paddr, IEN_OFF)) nxt_rd[1:0] = ien_ff;
      if (hit(paddr, INS_OFF)) nxt_rd[0] = ei_seen_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ff  <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else begin
      rd_ff  <= nxt_rd;
      err_ff <= nxt_err;
    end
  end

  assign core_request = req_ff[5:0] & mask_ff[5:0] & {6{mask_ff[MASTER_BIT]}};
  assign core_irq     = |core_request;
  assign irq          = |(stat_ff & ien_ff);

  a_master_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !mask_ff[MASTER_BIT] |-> !core_irq) else $error("request while master off");
  a_mask_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (core_request & ~mask_ff[5:0]) == 6'h00) else $error("masked source passed");
  a_req_lock: assert property (@(posedge pclk) disable iff (!presetn)
    (!ei_seen_ff && hw_set == 6'h00 && !grant_valid) |=> $stable(req_ff))
    else $error("request written before enable");
  a_service_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (grant_valid && grant_source == 3'd3 && !hw_set[3]) |=> !req_ff[3])
    else $error("serviced flag not cleared");
  a_grant_off: assert property (@(posedge pclk) disable iff (!presetn)
    (grant_valid && grant_source < 3'd6) |=> !mask_ff[MASTER_BIT])
    else $error("master not dropped on grant");
  a_pin1_set: assert property (@(posedge pclk) disable iff (!presetn)
    p1_edge |=> req_ff[2]) else $error("pin one edge lost");
  a_rx_set: assert property (@(posedge pclk) disable iff (!presetn)
    uart_rx_event |=> req_ff[0]) else $error("receive event lost");
  a_lv_set: assert property (@(posedge pclk) disable iff (!presetn)
    low_voltage_flag |=> req_ff[5]) else $error("low voltage lost");
  a_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, REQ_OFF) && ei_seen_ff && !pwdata[3] && !hw_set[3]) |=> !req_ff[3])
    else $error("software clear failed");
  c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn) $rose(core_irq));
  c_both_edges: cover property (@(posedge pclk) disable iff (!presetn)
    req_ff[7:6] == 2'h3 && p1_edge);
  c_grant: cover property (@(posedge pclk) disable iff (!presetn) grant_valid && core_irq);
  c_lock_refused: cover property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, REQ_OFF) && !ei_seen_ff);
  c_bad_grant: cover property (@(posedge pclk) disable iff (!presetn)
    grant_valid && !grant_ok);
  a_reset_master: assert property (@(posedge pclk)
    !presetn |=> !mask_ff[MASTER_BIT]) else $error("master on after reset");
  a_sw_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, REQ_OFF) && ei_seen_ff && pwdata[2] && !grant_ok) |=> req_ff[2])
    else $error("software set failed");
  a_pin2_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (req_ff[7:6] == 2'h1 && port3_pin2_input && !pin_ff[1]) |=> req_ff[0])
    else $error("pin two rise lost");
  a_pin1_blocked: assert property (@(posedge pclk) disable iff (!presetn)
    (req_ff[7:6] == 2'h0 && port3_pin1_input && !pin_ff[0]) |-> !p1_edge)
    else $error("pin one rise taken");
  a_pin3_set: assert property (@(posedge pclk) disable iff (!presetn)
    (!port3_pin3_input && pin_ff[2]) |=> req_ff[1])
    else $error("pin three edge lost");
  a_tx_set: assert property (@(posedge pclk) disable iff (!presetn)
    uart_tx_event |=> req_ff[1]) else $error("transmit event lost");
  a_timer_set: assert property (@(posedge pclk) disable iff (!presetn)
    eight_bit_timer |=> req_ff[4]) else $error("timer event lost");
  a_ei_master: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit(paddr, INS_OFF) && pwdata[1:0] == INS_EI && !grant_ok) |=> mask_ff[MASTER_BIT])
    else $error("enable not taken");
  a_bit6_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !mask_ff[6]) else $error("reserved mask bit set");
endmodule // irm_core
